// [core/fcl_buf.sv]
module fcl_buf
	import fcl_pkg::*;
#(
	parameter int W     = 32,
	parameter int DEPTH = 2
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst,
	input  wire logic         i_valid,
	output logic              o_ready,
	input  wire logic [W-1:0] i_data,
	output logic              o_valid,
	input  wire logic         i_ready,
	output logic [W-1:0]      o_data
);

	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [W-1:0] mem_q [DEPTH];
	logic [PW-1:0] wp_q;
	logic [PW-1:0] rp_q;
	logic [PW:0]   cnt_q;
	logic          push;
	logic          pop;

	function automatic logic [PW-1:0] nxt(logic [PW-1:0] p);
		nxt = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
	endfunction

	assign o_ready = (cnt_q != (PW + 1)'(DEPTH));
	assign o_valid = (cnt_q != '0);
	assign o_data  = mem_q[rp_q];
	assign push    = i_valid && o_ready;
	assign pop     = o_valid && i_ready;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wp_q <= nxt(wp_q);
			end
			if (pop) begin
				rp_q <= nxt(rp_q);
			end
			if (push && !pop) begin
				cnt_q <= cnt_q + (PW + 1)'(1);
			end else if (pop && !push) begin
				cnt_q <= cnt_q - (PW + 1)'(1);
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (push) begin
			mem_q[wp_q] <= i_data;
		end
	end

endmodule

// [core/fcl_config_memory_cells.sv]
module fcl_config_memory_cells
	import fcl_pkg::*;
#(
	parameter int AW = 10,
	parameter int DW = 32
) (
	input  wire logic          i_clk,
	input  wire logic          i_rst,
	input  wire logic          i_we,
	input  wire logic [AW-1:0] i_waddr,
	input  wire logic [DW-1:0] i_wdata,
	input  wire logic          i_re,
	input  wire logic [AW-1:0] i_raddr,
	output logic [DW-1:0]      o_rdata
);

	logic [DW-1:0] mem_q [2**AW];

	always_ff @(posedge i_clk) begin
		if (i_we) begin
			mem_q[i_waddr] <= i_wdata;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_rdata <= '0;
		end else if (i_re) begin
			o_rdata <= mem_q[i_raddr];
		end
	end

endmodule

// [core/fcl_loader.sv]
module fcl_loader
	import fcl_pkg::*;
#(
	parameter int CFG_WORDS = 1024,
	parameter int AW        = 10,
	parameter int DIV       = 2
) (
	input  wire logic          i_sys_clk,
	input  wire logic          i_rst,
	input  wire fcl_cfg_s      i_cfg,
	input  wire logic          i_configuration_reset_line_n,
	input  wire logic          i_external_cfg_clock_input,
	output fcl_spi_s           o_spi,
	input  wire logic [7:0]    i_spi_dq,
	input  wire logic          i_pas_clk,
	input  wire logic          i_pas_cs_n,
	input  wire logic [31:0]   i_pas_data,
	input  wire logic          i_jtag_tck,
	input  wire logic          i_jtag_tdi,
	input  wire logic          i_jtag_load,
	input  wire logic          i_rd_en,
	input  wire logic [AW-1:0] i_rd_addr,
	output logic [31:0]        o_rd_data,
	output fcl_stat_s          o_stat
);

	fcl_state_e    state_q;
	fcl_cfg_s      cfg_q;
	logic [SY_N-1:0] sy_in, s1_q, s2_q, s3_q, st_q, chg;
	logic          cr_rise, cr_low, tck_rise, tick, div_tick, start_ok;
	logic [7:0]    div_q;
	logic          sclk_q;
	logic [39:0]   sreg_q;
	logic [5:0]    bcnt_q;
	logic [15:0]   gap_q, pas_tmr_q;
	logic          pas_open, pas_take, pas_early;
	logic [31:0]   asm_q, nasm, a_dat, pend_q, new_d;
	logic [5:0]    acnt_q;
	logic [6:0]    nbits;
	logic          act_smp, jtg_smp, a_en, full, new_w, pend_v_q;
	logic          b_in_ready, b_out_v, b_out_r, wr, last_wr, sig_ok;
	logic [31:0]   b_out_d, csum_q;
	logic [AW-1:0] waddr_q;
	logic          bw_q, ovr_q, early_q;
	logic [3:0]    l1_q, l2_q, l3_q, lst_q;
	logic          lrst, lfull, ltgl_q;
	logic [2:0]    lw;
	logic [31:0]   lasm_q, lnasm, lword_q;
	logic [5:0]    lcnt_q;
	logic [6:0]    lnbits;

	// ----------------------------------------------------------------
	// Pin and link-toggle synchronisers
	// ----------------------------------------------------------------
	assign sy_in = {ltgl_q, i_jtag_load, i_jtag_tdi, i_jtag_tck,
		i_configuration_reset_line_n, i_external_cfg_clock_input};

	always_ff @(posedge i_sys_clk) begin
		s1_q <= sy_in;
		s2_q <= s1_q;
		s3_q <= s2_q;
	end

	for (genvar g = 0; g < SY_N; g++) begin : g_sync
		assign chg[g] = (s2_q[g] == s3_q[g]) && (s3_q[g] != st_q[g]);
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			st_q <= '0;
		end else begin
			st_q <= (st_q & ~chg) | (s3_q & chg);
		end
	end

	assign cr_rise  = chg[SY_CRST] && s3_q[SY_CRST];
	assign cr_low   = !st_q[SY_CRST] && !cr_rise;
	assign tck_rise = chg[SY_TCK] && s3_q[SY_TCK];
	assign start_ok = width_ok(i_cfg.mode, i_cfg.width, i_cfg.secure);

	// ----------------------------------------------------------------
	// Flash clock source
	// ----------------------------------------------------------------
	assign div_tick = (div_q == 8'(DIV - 1));
	assign tick     = cfg_q.ext_clk_sel ? chg[SY_EXT] : div_tick;

	always_ff @(posedge i_sys_clk) begin
		if (i_rst || div_tick) begin
			div_q <= '0;
		end else begin
			div_q <= div_q + 8'h01;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			cfg_q <= '0;
		end else if (cr_rise) begin
			cfg_q <= i_cfg;
		end
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	// The flash clock only advances on the falling half while a word waits,
	// so a slow memory write throttles the flash instead of dropping data.
	always_ff @(posedge i_sys_clk) begin
		if (i_rst || cr_low) begin
			state_q <= S_IDLE;
			sclk_q  <= 1'b0;
			sreg_q  <= '0;
			bcnt_q  <= '0;
			gap_q   <= '0;
		end else if (last_wr) begin
			state_q <= sig_ok ? S_USER : S_FAIL;
			sclk_q  <= 1'b0;
		end else begin
			case (state_q)
				S_IDLE: begin
					if (cr_rise) begin
						if (!start_ok) begin
							state_q <= S_FAIL;
						end else if (i_cfg.mode == FCL_ACTIVE) begin
							state_q <= S_WAKE;
							sreg_q  <= {OP_WAKE, 32'h0};
							bcnt_q  <= OP_BITS;
						end else begin
							state_q <= S_RECV;
						end
					end
				end
				S_WAKE, S_CMD, S_DUMMY, S_STREAM: begin
					if (tick && sclk_q) begin
						sclk_q <= 1'b0;
						if (bcnt_q != '0) begin
							sreg_q <= {sreg_q[38:0], 1'b0};
						end else if (state_q == S_WAKE) begin
							state_q <= S_GAP;
							gap_q   <= '0;
						end else if (state_q == S_CMD) begin
							state_q <= S_DUMMY;
							bcnt_q  <= DUMMY_CLKS;
						end else if (state_q == S_DUMMY) begin
							state_q <= S_STREAM;
						end
					end else if (tick && !(state_q == S_STREAM && pend_v_q)) begin
						sclk_q <= 1'b1;
						if (state_q != S_STREAM) begin
							bcnt_q <= bcnt_q - 6'h01;
						end
					end
				end
				S_GAP: begin
					gap_q <= gap_q + 16'h0001;
					if (gap_q == 16'(WAKE_CYC - 1)) begin
						state_q <= S_CMD;
						if (cfg_q.addr4) begin
							sreg_q <= {OP_FREAD, START_ADDR};
							bcnt_q <= CMD4_BITS;
						end else begin
							sreg_q <= {OP_FREAD, START_ADDR[23:0], 8'h00};
							bcnt_q <= CMD3_BITS;
						end
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_comb begin
		o_spi.sclk    = sclk_q;
		o_spi.cs_n    = !(state_q inside {S_WAKE, S_CMD, S_DUMMY, S_STREAM});
		o_spi.dq      = {7'h00, sreg_q[39]};
		o_spi.dq_oe_n = {7'h7f, !(state_q inside {S_WAKE, S_CMD})};
	end

	// ----------------------------------------------------------------
	// Word assembly
	// ----------------------------------------------------------------
	assign act_smp = (state_q == S_STREAM) && tick && !sclk_q && !pend_v_q;
	assign jtg_smp = (state_q == S_RECV) && (cfg_q.mode == FCL_JTAG)
		&& tck_rise && st_q[SY_LOAD];
	assign a_en  = act_smp || jtg_smp;
	assign a_dat = act_smp ? {24'h0, i_spi_dq} : {31'h0, st_q[SY_TDI]};
	assign nasm  = shift_in(asm_q, a_dat, cfg_q.width);
	assign nbits = {1'b0, acnt_q} + lanes(cfg_q.width);
	assign full  = (nbits == WORD_BITS);

	always_ff @(posedge i_sys_clk) begin
		if (i_rst || state_q == S_IDLE) begin
			acnt_q <= '0;
			asm_q  <= '0;
		end else if (a_en) begin
			asm_q  <= nasm;
			acnt_q <= full ? 6'h00 : nbits[5:0];
		end
	end

	// Passive words are only taken once the hold-off after release expired.
	assign pas_open  = (pas_tmr_q == 16'(PAS_CYC));
	assign pas_take  = chg[SY_TGL] && (state_q == S_RECV)
		&& (cfg_q.mode == FCL_PASSIVE) && pas_open;
	assign pas_early = chg[SY_TGL] && (cfg_q.mode == FCL_PASSIVE) && !pas_open;
	assign new_w = (a_en && full) || pas_take;
	assign new_d = pas_take ? lword_q : nasm;

	always_ff @(posedge i_sys_clk) begin
		if (i_rst || cr_rise) begin
			pas_tmr_q <= '0;
		end else if (!pas_open) begin
			pas_tmr_q <= pas_tmr_q + 16'h0001;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst || state_q == S_IDLE) begin
			pend_v_q <= 1'b0;
			pend_q   <= '0;
		end else if (new_w) begin
			pend_v_q <= 1'b1;
			pend_q   <= new_d;
		end else if (b_in_ready) begin
			pend_v_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Buffer, writer and configuration memory
	// ----------------------------------------------------------------
	fcl_buf #(
		.W     (32),
		.DEPTH (2)
	) u_buf (
		.i_clk   (i_sys_clk),
		.i_rst   (i_rst || state_q == S_IDLE),
		.i_valid (pend_v_q),
		.o_ready (b_in_ready),
		.i_data  (pend_q),
		.o_valid (b_out_v),
		.i_ready (b_out_r),
		.o_data  (b_out_d)
	);

	// A read-back request takes the memory port, so loading stalls meanwhile.
	assign b_out_r = !i_rd_en && (state_q inside {S_STREAM, S_RECV});
	assign wr      = b_out_v && b_out_r;
	assign last_wr = wr && (waddr_q == AW'(CFG_WORDS - 1));
	assign sig_ok  = !cfg_q.auth_en || (b_out_d == csum_q);

	always_ff @(posedge i_sys_clk) begin
		if (i_rst || state_q == S_IDLE) begin
			waddr_q <= '0;
			csum_q  <= '0;
		end else if (wr) begin
			waddr_q <= waddr_q + AW'(1);
			csum_q  <= csum_q ^ b_out_d;
		end
	end

	fcl_config_memory_cells #(
		.AW (AW),
		.DW (32)
	) u_config_memory_cells (
		.i_clk   (i_sys_clk),
		.i_rst   (i_rst),
		.i_we    (wr),
		.i_waddr (waddr_q),
		.i_wdata (b_out_d),
		.i_re    (i_rd_en),
		.i_raddr (i_rd_addr),
		.o_rdata (o_rd_data)
	);

	// ----------------------------------------------------------------
	// Status
	// ----------------------------------------------------------------
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			bw_q    <= 1'b0;
			ovr_q   <= 1'b0;
			early_q <= 1'b0;
		end else begin
			if (cr_rise) begin
				bw_q <= !start_ok;
			end
			if (new_w && pend_v_q && !b_in_ready) begin
				ovr_q <= 1'b1;
			end else if (cr_rise) begin
				ovr_q <= 1'b0;
			end
			if (pas_early) begin
				early_q <= 1'b1;
			end else if (cr_rise) begin
				early_q <= 1'b0;
			end
		end
	end

	always_comb begin
		o_stat.loading   = !(state_q inside {S_IDLE, S_USER, S_FAIL});
		o_stat.user_mode = (state_q == S_USER);
		o_stat.cfg_error = (state_q == S_FAIL);
		o_stat.bad_width = bw_q;
		o_stat.overrun   = ovr_q;
		o_stat.early     = early_q;
	end

	// ----------------------------------------------------------------
	// Passive link domain
	// ----------------------------------------------------------------
	// Width is taken as static during a frame; a change mid-frame garbles it.
	always_ff @(posedge i_pas_clk) begin
		l1_q  <= {i_cfg.width, i_rst};
		l2_q  <= l1_q;
		l3_q  <= l2_q;
		lst_q <= (lst_q & (l2_q ^ l3_q)) | (l3_q & ~(l2_q ^ l3_q));
	end

	assign lrst   = lst_q[0];
	assign lw     = lst_q[3:1];
	assign lnasm  = shift_in(lasm_q, i_pas_data, lw);
	assign lnbits = {1'b0, lcnt_q} + lanes(lw);
	assign lfull  = (lnbits == WORD_BITS);

	always_ff @(posedge i_pas_clk) begin
		if (lrst) begin
			lcnt_q  <= '0;
			ltgl_q  <= 1'b0;
			lasm_q  <= '0;
			lword_q <= '0;
		end else if (i_pas_cs_n) begin
			lcnt_q <= '0;
		end else begin
			lasm_q <= lnasm;
			if (lfull) begin
				lword_q <= lnasm;
				ltgl_q  <= !ltgl_q;
				lcnt_q  <= '0;
			end else begin
				lcnt_q <= lnbits[5:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);

	wake_first_a: assert property ($rose(state_q == S_WAKE) |->
		o_spi.dq[0] == OP_WAKE[7] && !o_spi.dq_oe_n[0] && !o_spi.cs_n)
		else $error("wake-up command not first on the line");
	wake_gap_a: assert property ($rose(state_q == S_CMD) |->
		$past(gap_q) == 16'(WAKE_CYC - 1) && $past(o_spi.cs_n))
		else $error("wake-up delay too short");
	read_cmd_a: assert property ($rose(state_q == S_CMD) |->
		sreg_q[39:32] == OP_FREAD && $past(state_q) == S_GAP)
		else $error("fast read not issued after delay");
	zero_addr_a: assert property ($rose(state_q == S_CMD) |->
		sreg_q[31:0] == 32'h0 && bcnt_q == (cfg_q.addr4 ? CMD4_BITS : CMD3_BITS))
		else $error("fast read address not zero");
	auto_start_a: assert property ((state_q == S_IDLE && cr_rise && start_ok
		&& i_cfg.mode == FCL_ACTIVE) |=> state_q == S_WAKE)
		else $error("active load did not start");
	bad_width_a: assert property ((state_q == S_IDLE && cr_rise && !start_ok)
		|=> state_q == S_FAIL && o_stat.bad_width)
		else $error("illegal width accepted");
	flash_stall_a: assert property ((state_q == S_STREAM && pend_v_q
		&& !sclk_q) |=> !sclk_q)
		else $error("flash clocked while a word waits");
	pas_hold_a: assert property (cr_rise |=> !pas_open [*8])
		else $error("passive hold-off not applied");
	sig_fail_a: assert property ((last_wr && !sig_ok) |=>
		o_stat.cfg_error && !o_stat.user_mode)
		else $error("bad signature reached user mode");
	hand_over_a: assert property ((last_wr && sig_ok) |=>
		o_stat.user_mode && !o_stat.loading)
		else $error("no hand-over after last word");

	active_user_c: cover property (state_q == S_STREAM ##[1:1000] state_q == S_USER);
	passive_user_c: cover property (pas_take ##[1:1000] state_q == S_USER);
	jtag_word_c: cover property (jtg_smp && full);
	sig_fail_c: cover property (last_wr && !sig_ok);

endmodule

// [include/fcl_pkg.sv]
package fcl_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int SYS_PERIOD_NS = 20;
	localparam int T_WAKE_NS     = 30000;
	localparam int WAKE_CYC      = (T_WAKE_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
	localparam int T_PAS_NS      = 32000;
	localparam int PAS_CYC       = (T_PAS_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;

	// ----------------------------------------------------------------
	// Flash commands and framing
	// ----------------------------------------------------------------
	localparam logic [7:0]  OP_WAKE    = 8'hab;
	localparam logic [7:0]  OP_FREAD   = 8'h0b;
	localparam logic [31:0] START_ADDR = 32'h00000000;
	localparam logic [5:0]  OP_BITS    = 6'h08;
	localparam logic [5:0]  CMD3_BITS  = 6'h20;
	localparam logic [5:0]  CMD4_BITS  = 6'h28;
	localparam logic [5:0]  DUMMY_CLKS = 6'h08;
	localparam logic [6:0]  WORD_BITS  = 7'h20;

	// ----------------------------------------------------------------
	// Width codes and synchroniser slots
	// ----------------------------------------------------------------
	localparam logic [2:0] W_X1  = 3'h0;
	localparam logic [2:0] W_X2  = 3'h1;
	localparam logic [2:0] W_X4  = 3'h2;
	localparam logic [2:0] W_X8  = 3'h3;
	localparam logic [2:0] W_X16 = 3'h4;
	localparam logic [2:0] W_X32 = 3'h5;
	localparam int SY_EXT  = 0;
	localparam int SY_CRST = 1;
	localparam int SY_TCK  = 2;
	localparam int SY_TDI  = 3;
	localparam int SY_LOAD = 4;
	localparam int SY_TGL  = 5;
	localparam int SY_N    = 6;

	typedef enum logic [1:0] {FCL_ACTIVE, FCL_PASSIVE, FCL_JTAG} fcl_mode_e;

	typedef enum logic [3:0] {
		S_IDLE, S_WAKE, S_GAP, S_CMD, S_DUMMY, S_STREAM, S_RECV, S_USER, S_FAIL
	} fcl_state_e;

	typedef struct packed {
		fcl_mode_e  mode;
		logic [2:0] width;
		logic       secure;
		logic       addr4;
		logic       ext_clk_sel;
		logic       auth_en;
	} fcl_cfg_s;

	typedef struct packed {
		logic       sclk;
		logic       cs_n;
		logic [7:0] dq;
		logic [7:0] dq_oe_n;
	} fcl_spi_s;

	typedef struct packed {
		logic loading;
		logic user_mode;
		logic cfg_error;
		logic bad_width;
		logic overrun;
		logic early;
	} fcl_stat_s;

	function automatic logic width_ok(fcl_mode_e m, logic [2:0] w, logic sec);
		case (m)
			FCL_ACTIVE:  width_ok = (w <= W_X8);
			FCL_PASSIVE: width_ok = (w <= W_X8) || ((w <= W_X32) && !sec);
			default:     width_ok = (w == W_X1);
		endcase
	endfunction

	function automatic logic [31:0] shift_in(logic [31:0] w, logic [31:0] d, logic [2:0] c);
		case (c)
			W_X1:    shift_in = {w[30:0], d[0]};
			W_X2:    shift_in = {w[29:0], d[1:0]};
			W_X4:    shift_in = {w[27:0], d[3:0]};
			W_X8:    shift_in = {w[23:0], d[7:0]};
			W_X16:   shift_in = {w[15:0], d[15:0]};
			default: shift_in = d;
		endcase
	endfunction

	function automatic logic [6:0] lanes(logic [2:0] c);
		lanes = 7'h01 << c;
	endfunction

endpackage

// [test/fcl_flash_model.sv]
module fcl_flash_model
	import fcl_pkg::*;
(
	input  wire logic         i_sclk,
	input  wire logic         i_cs_n,
	input  wire logic [7:0]   i_dq,
	input  wire logic [2:0]   i_width,
	input  wire logic         i_addr4,
	input  wire logic [127:0] i_image,
	output logic [7:0]        o_dq,
	output logic [7:0]        o_prev_op,
	output logic [7:0]        o_last_op,
	output logic [31:0]       o_addr,
	output int                o_rises
);
	timeunit 1ns;
	timeprecision 1ps;

	// --------------------
	// Frame decoding
	// --------------------
	logic [7:0]  op;
	logic [31:0] addr;
	int          ptr;
	int          hdr;
	int          n;

	assign hdr = i_addr4 ? 32 : 24;
	assign n   = (i_width > 3'h3) ? 8 : (1 << i_width);

	initial begin
		o_dq = 8'h00;
		o_prev_op = 8'h00;
		o_last_op = 8'h00;
		o_addr = 32'hffffffff;
		o_rises = 0;
	end

	always @(negedge i_cs_n) begin
		o_rises = 0;
		op = 8'h00;
		addr = 32'h00000000;
		ptr = 127;
	end

	always @(posedge i_sclk) begin
		if (!i_cs_n) begin
			o_rises = o_rises + 1;
			if (o_rises <= 8) op = {op[6:0], i_dq[0]};
			else if (o_rises <= 8 + hdr) addr = {addr[30:0], i_dq[0]};
		end
	end

	// A released line shows the inverse, so a stale value is never mistaken for data.
	always @(posedge i_cs_n) begin
		o_prev_op = o_last_op;
		o_last_op = op;
		o_addr = addr;
		o_dq = ~o_dq;
	end

	// --------------------
	// Data phase
	// --------------------
	// Data leaves the flash only after opcode, address and dummy clocks.
	always @(negedge i_sclk) begin
		if (!i_cs_n && o_rises >= 16 + hdr) begin
			o_dq = ~o_dq;
			for (int i = 0; i < n; i++) begin
				if (ptr >= 0) begin
					o_dq[n - 1 - i] = i_image[ptr];
					ptr = ptr - 1;
				end
			end
		end
	end
endmodule

// [test/testbench.sv]
module testbench
	import fcl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// --------------------
	// Signals
	// --------------------
	localparam int NW = 4;
	logic         i_sys_clk;
	logic         i_rst;
	fcl_cfg_s     cfg;
	logic         crst_n;
	logic         ext_clk;
	logic         ext_run;
	logic         pas_clk;
	logic         pas_cs_n;
	logic [31:0]  pas_data;
	logic         tck;
	logic         tdi;
	logic         tload;
	logic         rd_en;
	logic [9:0]   rd_addr;
	logic [31:0]  rd_data;
	fcl_spi_s     spi;
	fcl_stat_s    stat;
	logic [7:0]   flash_dq;
	logic [7:0]   dq_bus;
	logic [7:0]   prev_op;
	logic [7:0]   last_op;
	logic [31:0]  flash_addr;
	int           flash_rises;
	logic [127:0] image;
	logic [6:0]   tbl [6];
	int           mismatches;
	int           checks;
	int           cyc;
	int           n;

	assign dq_bus = {flash_dq[7:1], spi.dq_oe_n[0] ? flash_dq[0] : spi.dq[0]};

	fcl_loader #(
		.CFG_WORDS(NW),
		.AW(10),
		.DIV(2)
	) u_dut (
		.i_sys_clk                   (i_sys_clk),
		.i_rst                       (i_rst),
		.i_cfg                       (cfg),
		.i_configuration_reset_line_n(crst_n),
		.i_external_cfg_clock_input  (ext_clk),
		.o_spi                       (spi),
		.i_spi_dq                    (dq_bus),
		.i_pas_clk                   (pas_clk),
		.i_pas_cs_n                  (pas_cs_n),
		.i_pas_data                  (pas_data),
		.i_jtag_tck                  (tck),
		.i_jtag_tdi                  (tdi),
		.i_jtag_load                 (tload),
		.i_rd_en                     (rd_en),
		.i_rd_addr                   (rd_addr),
		.o_rd_data                   (rd_data),
		.o_stat                      (stat)
	);

	fcl_flash_model u_flash (
		.i_sclk   (spi.sclk),
		.i_cs_n   (spi.cs_n),
		.i_dq     (dq_bus),
		.i_width  (cfg.width),
		.i_addr4  (cfg.addr4),
		.i_image  (image),
		.o_dq     (flash_dq),
		.o_prev_op(prev_op),
		.o_last_op(last_op),
		.o_addr   (flash_addr),
		.o_rises  (flash_rises)
	);

	// --------------------
	// Tasks
	// --------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic start(input fcl_mode_e m, input logic [2:0] w, input logic s,
			input logic a4, input logic ext);
		@(negedge i_sys_clk);
		crst_n = 1'b0;
		cfg = '{m, w, s, a4, ext, 1'b1};
		repeat (6) @(negedge i_sys_clk);
		crst_n = 1'b1;
		repeat (6) @(negedge i_sys_clk);
	endtask

	task automatic finish_load();
		n = 0;
		while (!(stat.user_mode || stat.cfg_error) && n < 20000) begin
			@(negedge i_sys_clk);
			n++;
		end
		repeat (2) @(negedge i_sys_clk);
	endtask

	task automatic wait_cs(input logic v);
		n = 0;
		while (spi.cs_n !== v && n < 3000) begin
			@(negedge i_sys_clk);
			n++;
		end
	endtask

	task automatic readback();
		for (int k = 0; k < NW; k++) begin
			rd_en = 1'b1;
			rd_addr = 10'(k);
			@(negedge i_sys_clk);
			rd_en = 1'b0;
			@(negedge i_sys_clk);
			check(rd_data, image[127 - 32 * k -: 32]);
		end
	endtask

	// The link clock runs only inside a frame; words stay well above the pacing limit.
	task automatic pas_send(input logic [31:0] w);
		pas_cs_n = 1'b0;
		for (int i = 0; i < 4; i++) begin
			pas_data = {24'h000000, w[31 - 8 * i -: 8]};
			#24 pas_clk = 1'b1;
			#24 pas_clk = 1'b0;
		end
		pas_cs_n = 1'b1;
		pas_data = ~pas_data;
		#48;
	endtask

	task automatic jtag_load();
		start(FCL_JTAG, W_X1, 1'b0, 1'b0, 1'b0);
		repeat (PAS_CYC) @(negedge i_sys_clk);
		tload = 1'b1;
		for (int i = 127; i >= 0; i--) begin
			tdi = image[i];
			repeat (4) @(negedge i_sys_clk);
			tck = 1'b1;
			repeat (4) @(negedge i_sys_clk);
			tck = 1'b0;
		end
		tload = 1'b0;
		finish_load();
	endtask

	// --------------------
	// Clocks and watchdog
	// --------------------
	initial begin
		i_sys_clk = 1'b0;
		forever #10 i_sys_clk = ~i_sys_clk;
	end

	initial begin
		forever begin
			repeat (4) @(negedge i_sys_clk);
			if (ext_run) ext_clk = ~ext_clk;
		end
	end

	initial begin
		cyc = 0;
		forever begin
			@(posedge i_sys_clk);
			cyc++;
			if (cyc == 30000) begin
				mismatches++;
				tally_and_finish();
			end
		end
	end

	// --------------------
	// Sequence
	// --------------------
	initial begin
		{i_rst, pas_cs_n, crst_n, ext_clk, ext_run, pas_clk, tck, tdi, tload, rd_en} = 10'h300;
		cfg = '0;
		pas_data = 32'h00000000;
		rd_addr = 10'h000;
		mismatches = 0;
		checks = 0;
		image = {32'hc3a50f1e, 32'h80017ffe, 32'h5a5aa5a5, 32'h00000000};
		image[31:0] = image[127:96] ^ image[95:64] ^ image[63:32];
		tbl = '{7'h11, 7'h45, 7'h33, 7'h37, 7'h34, 7'h0e};
		// The link domain needs its own edges while reset is held.
		repeat (20) #5 pas_clk = ~pas_clk;
		i_rst = 1'b0;
		repeat (4) @(negedge i_sys_clk);
		check(32'(spi), 32'h000100ff);
		check(32'(stat), 32'h00000000);

		start(FCL_ACTIVE, W_X4, 1'b0, 1'b0, 1'b0);
		check(32'(stat.loading), 32'h00000001);
		wait_cs(1'b1);
		wait_cs(1'b0);
		check(32'(n >= WAKE_CYC && n <= WAKE_CYC + 2), 32'h00000001);
		finish_load();
		check(32'(stat.user_mode), 32'h00000001);
		check(32'(prev_op), 32'(OP_WAKE));
		check(32'(last_op), 32'(OP_FREAD));
		check(flash_addr, START_ADDR);
		readback();

		start(FCL_ACTIVE, W_X8, 1'b0, 1'b1, 1'b1);
		repeat (100) @(negedge i_sys_clk);
		check(32'(flash_rises), 32'h00000000);
		check(32'(spi.cs_n), 32'h00000000);
		ext_run = 1'b1;
		finish_load();
		ext_run = 1'b0;
		check(32'(stat.user_mode), 32'h00000001);
		check(flash_addr, START_ADDR);
		readback();

		start(FCL_PASSIVE, W_X8, 1'b1, 1'b0, 1'b0);
		// Idle link edges carry reset release and width across before any frame.
		repeat (8) #24 pas_clk = ~pas_clk;
		pas_send(32'h0f0f0f0f);
		repeat (10) @(negedge i_sys_clk);
		check(32'(stat.early), 32'h00000001);
		repeat (PAS_CYC) @(negedge i_sys_clk);
		for (int k = 0; k < NW; k++) pas_send(image[127 - 32 * k -: 32]);
		finish_load();
		check(32'(stat.user_mode), 32'h00000001);
		check(32'(stat.overrun), 32'h00000000);
		readback();

		jtag_load();
		check(32'(stat.user_mode), 32'h00000001);
		readback();
		image[0] = ~image[0];
		jtag_load();
		check(32'(stat.cfg_error), 32'h00000001);
		check(32'(stat.user_mode), 32'h00000000);

		// Each entry: mode, width, secure, expected refusal.
		foreach (tbl[t]) begin
			start(fcl_mode_e'(tbl[t][6:5]), tbl[t][4:2], tbl[t][1], 1'b0, 1'b0);
			check(32'({stat.bad_width, stat.cfg_error, stat.loading}),
				{29'h0, tbl[t][0], tbl[t][0], ~tbl[t][0]});
		end
		tally_and_finish();
	end
endmodule
